// ===== logic/hrt_pkg.sv
package hrt_pkg;

	// ---------------------------------------------------------------
	// Timing constants, counted in oscillator periods
	// ---------------------------------------------------------------
	localparam int unsigned DEBOUNCE_PERIODS = 6;
	localparam int unsigned HOLD_PERIODS     = 73728;
	localparam int          HOLD_W           = 17;
	localparam int          DEB_W            = 3;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic       RELAY_RST = 1'b0;
	localparam logic [2:0] IN_RST    = 3'h0;

	// Debounced control inputs, active high after polarity correction
	typedef struct packed {
		logic sw_on;
		logic sw_off;
		logic toggle;
	} hrt_in_t;

	typedef enum logic {
		HRT_IDLE,
		HRT_HOLD
	} hrt_state_t;

endpackage

// ===== logic/hrt_timer.sv
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Debounce six periods, hold 73728 periods
// - Power-on reset leaves relay off
// - Only three inputs start or stop timing
// - Trigger asserts relay, expiry releases it
// - First toggle press asserts after debounce
// - Each toggle press inverts relay state
// - Unpressed toggle holds relay until expiry
// - Switch-on press asserts after debounce
// - Switch-off press releases relay after debounce
// - Switch-on activation releases at expiry
// - One shared debouncer serves all inputs
// - Press and release both debounced
// - Held switch-on does not restart timing
// - No retrigger while relay active
// - High-side variant: high level means pressed
// - Ground variant: low level means pressed
module hrt_timer
	import hrt_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = HOLD_PERIODS, // Shorten for simulation
	parameter bit          ACTIVE_LOW  = 1'b0          // 1: ground-switched variant
) (
	input  wire logic core_clk,    // Oscillator clock
	input  wire logic rst_n,       // Power-on reset, active low
	input  wire logic sw_on_pin,   // Switch-on pushbutton pin
	input  wire logic sw_off_pin,  // Switch-off pushbutton pin
	input  wire logic toggle_pushbutton, // Toggle pushbutton pin
	output logic      relay_drive  // Relay driver on, active high
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [2:0]        s1;     // Synchroniser stage one
		logic [2:0]        s2;
		logic [2:0]        s3;
		hrt_in_t           cand;   // Level under test
		hrt_in_t           stable; // Accepted level
		logic [DEB_W-1:0]  deb_cnt;
		hrt_state_t        state;
		logic [HOLD_W-1:0] hold_cnt;
		logic              relay;
	} hrt_st_t;

	hrt_st_t q, d;
	logic [2:0] pin_vec;
	hrt_in_t    samp;
	hrt_in_t    rise;

	// Polarity correction for both variants
	// input polarity
	assign pin_vec = ACTIVE_LOW ? ~{sw_on_pin, sw_off_pin, toggle_pushbutton}
	                            :  {sw_on_pin, sw_off_pin, toggle_pushbutton};

	// Agreed sample of stages two and three; stage one feeds only stage two
	assign samp = hrt_in_t'(q.s2 & q.s3 | q.cand & (q.s2 ^ q.s3));

	// ---------------------------------------------------------------
	// Next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		d      = q;
		rise   = '0;
		d.s1   = pin_vec;
		d.s2   = q.s1;
		d.s3   = q.s2;
		if (samp != q.cand) begin
			d.cand    = samp;     // Any change on any input restarts the wait
			d.deb_cnt = '0;
		end else if (q.stable != q.cand) begin
			if (q.deb_cnt == DEB_W'(DEBOUNCE_PERIODS - 1)) begin
				d.stable  = q.cand;
				d.deb_cnt = '0;
				rise      = hrt_in_t'(q.cand & ~q.stable);
			end else begin
				d.deb_cnt = q.deb_cnt + DEB_W'(1);
			end
		end else begin
			d.deb_cnt = '0;
		end

		// Relay control; switch-off takes priority over the others
		// input-driven events and hold expiry
		case (q.state)
			HRT_IDLE: begin
				if (!rise.sw_off && (rise.sw_on || rise.toggle)) begin
					d.state    = HRT_HOLD;
					d.relay    = 1'b1;
					d.hold_cnt = '0;
				end
			end
			HRT_HOLD: begin
				if (rise.sw_off || rise.toggle) begin
					d.state    = HRT_IDLE;
					d.relay    = 1'b0;
					d.hold_cnt = '0;
				end else if (q.hold_cnt == HOLD_W'(HOLD_CYCLES - 1)) begin
					d.state    = HRT_IDLE;
					d.relay    = 1'b0;
					d.hold_cnt = '0;
				end else begin
					d.hold_cnt = q.hold_cnt + HOLD_W'(1);
				end
			end
			default: begin
				d.state = HRT_IDLE;
				d.relay = 1'b0;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// defined state at power-on
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q.s1       <= IN_RST;
			q.s2       <= IN_RST;
			q.s3       <= IN_RST;
			q.cand     <= '0;
			q.stable   <= '0;
			q.deb_cnt  <= '0;
			q.state    <= HRT_IDLE;
			q.hold_cnt <= '0;
			q.relay    <= RELAY_RST;
		end else begin
			q <= d;
		end
	end

	// Output taken straight from its flop: no decode glitch reaches the
	// relay driver, at the cost of one edge of latency
	assign relay_drive = q.relay;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_on_press;
		q.state == HRT_IDLE && rise.sw_on && !rise.sw_off;
	endsequence

	a_on_asserts: assert property (s_on_press |=> relay_drive)
		else $error("switch-on press did not assert relay");
	a_off_releases: assert property (relay_drive && rise.sw_off |=> !relay_drive)
		else $error("switch-off press did not release relay");
	a_toggle_inverts: assert property (rise.toggle && !rise.sw_off && !rise.sw_on
		|=> relay_drive != $past(relay_drive))
		else $error("toggle press did not invert relay");
	a_expiry_release: assert property (relay_drive && q.hold_cnt == HOLD_W'(HOLD_CYCLES - 1)
		|=> !relay_drive)
		else $error("relay not released at expiry");
	a_no_retrigger: assert property (relay_drive && relay_drive == $past(relay_drive)
		&& $past(relay_drive) |-> q.hold_cnt == $past(q.hold_cnt) + HOLD_W'(1))
		else $error("hold counter restarted while active");
	a_cnt_cleared: assert property (!relay_drive |-> q.hold_cnt == '0)
		else $error("hold counter not cleared while off");
	a_deb_stable: assert property ($changed(q.stable) |-> $past(q.cand) == q.stable
		&& $past(q.deb_cnt) == DEB_W'(DEBOUNCE_PERIODS - 1))
		else $error("input accepted before stable interval");
	a_relay_cause: assert property ($rose(relay_drive) |-> $past(rise.sw_on || rise.toggle))
		else $error("relay started without input press");

	// The checks below look at the state register, its agreed sample and the accept strobe
	// only; they hold for either input polarity because correction is
	// done before the first flop. Hold lengths follow HOLD_CYCLES, so a
	// shortened simulation hold exercises the same expiry path as the
	// full-length one.

	// ---------------------------------------------------------------
	// Input chain checks
	// ---------------------------------------------------------------
	// Each stage takes the one before it; a stage that skipped would
	// let a metastable first-stage value reach the debounce logic
	// synchroniser order
	a_sync_second: assert property (q.s2 == $past(q.s1))
		else $error("second stage did not follow first stage");

	a_sync_third: assert property (q.s3 == $past(q.s2))
		else $error("third stage did not follow second stage");

	// Stages two and three agreeing decide the next candidate
	// agreement rule
	a_cand_follow: assert property (q.s2 == q.s3
		|=> q.cand == hrt_in_t'($past(q.s2)))
		else $error("candidate did not take agreed sample");

	// Split stages leave those candidate bits alone, so a pin edge
	// that lands between the stages cannot flip the candidate twice
	// split stages hold
	a_cand_keep: assert property (((3'(q.cand) ^ 3'($past(q.cand)))
		& $past(q.s2 ^ q.s3)) == 3'h0)
		else $error("candidate moved while stages disagreed");

	// ---------------------------------------------------------------
	// Debounce checks
	// ---------------------------------------------------------------
	sequence s_deb_counting;
		samp == q.cand && q.stable != q.cand && q.deb_cnt != DEB_W'(DEBOUNCE_PERIODS - 1);
	endsequence

	sequence s_deb_accept;
		samp == q.cand && q.stable != q.cand && q.deb_cnt == DEB_W'(DEBOUNCE_PERIODS - 1);
	endsequence

	// Any candidate change, on any of the three inputs, restarts the
	// one shared wait; mixing inputs therefore costs extra delay
	// shared restart
	a_deb_restart: assert property (samp != q.cand |=> q.deb_cnt == '0)
		else $error("debounce wait not restarted on change");

	a_deb_zero_start: assert property ($changed(q.cand) |-> q.deb_cnt == '0)
		else $error("candidate changed without count restart");

	a_deb_step: assert property (s_deb_counting
		|=> q.deb_cnt == $past(q.deb_cnt) + DEB_W'(1))
		else $error("debounce count did not advance");

	// Release is debounced like the press, so the accepted level takes
	// the candidate in both directions
	// both edges accepted
	a_deb_accept: assert property (s_deb_accept |=> q.stable == $past(q.cand))
		else $error("accepted level did not take candidate");

	a_deb_idle: assert property (samp == q.cand && q.stable == q.cand
		|=> q.deb_cnt == '0)
		else $error("debounce count ran while settled");

	a_deb_settled: assert property (samp == q.cand && q.stable == q.cand
		|=> $stable(q.stable))
		else $error("accepted level moved while settled");

	a_stable_hold: assert property (samp != q.cand |=> $stable(q.stable))
		else $error("level accepted during input change");

	a_deb_bound: assert property (q.deb_cnt <= DEB_W'(DEBOUNCE_PERIODS - 1))
		else $error("debounce count beyond interval");

	a_rise_needs_accept: assert property (rise != '0 |-> s_deb_accept)
		else $error("press strobe without acceptance");

	// Two accepted events are at least one full interval apart
	// accept spacing
	a_accept_gap: assert property (rise != '0 |=> (rise == '0) [*6])
		else $error("second event inside debounce interval");

	// ---------------------------------------------------------------
	// Relay and hold counter checks
	// ---------------------------------------------------------------
	sequence s_hold_quiet;
		q.state == HRT_HOLD && rise == '0 && q.hold_cnt != HOLD_W'(HOLD_CYCLES - 1);
	endsequence

	sequence s_hold_expiry;
		q.state == HRT_HOLD && rise == '0 && q.hold_cnt == HOLD_W'(HOLD_CYCLES - 1);
	endsequence

	// The state and the output register must never disagree; the output
	// has its own flop so the pin never sees a decode glitch
	// state matches output
	a_state_match: assert property (relay_drive == (q.state == HRT_HOLD))
		else $error("relay output and state disagree");

	a_idle_quiet: assert property (q.state == HRT_IDLE && rise == '0 |=> !relay_drive)
		else $error("relay started with no accepted press");

	a_on_start: assert property (q.state == HRT_IDLE && rise.sw_on && !rise.sw_off
		|=> q.hold_cnt == '0)
		else $error("switch-on start did not clear counter");

	a_toggle_start: assert property (q.state == HRT_IDLE && rise.toggle && !rise.sw_off
		|=> relay_drive && q.hold_cnt == '0)
		else $error("toggle press did not start hold");

	a_toggle_release: assert property (q.state == HRT_HOLD && rise.toggle
		|=> !relay_drive && q.hold_cnt == '0)
		else $error("toggle press did not end hold");

	a_hold_step: assert property (s_hold_quiet
		|=> relay_drive && q.hold_cnt == $past(q.hold_cnt) + HOLD_W'(1))
		else $error("hold count did not advance");

	a_expiry_clear: assert property (s_hold_expiry |=> !relay_drive && q.hold_cnt == '0)
		else $error("expiry did not stop and clear");

	a_start_clear: assert property ($rose(relay_drive) |-> q.hold_cnt == '0)
		else $error("hold count not zero at start");

	a_stop_clear: assert property ($fell(relay_drive) |-> q.hold_cnt == '0)
		else $error("hold count not zero at stop");

	a_count_needs_hold: assert property (q.hold_cnt != '0 |-> relay_drive)
		else $error("hold count running while off");

	a_hold_bound: assert property (q.hold_cnt <= HOLD_W'(HOLD_CYCLES - 1))
		else $error("hold count beyond interval");

	// Switch-off wins over on and toggle accepted in the same cycle
	// off has priority
	a_off_wins: assert property (rise.sw_off |=> !relay_drive)
		else $error("relay on after switch-off press");

	// A second switch-on press while holding neither restarts nor stops
	// on press ignored
	a_on_ignored: assert property (q.state == HRT_HOLD && rise.sw_on && !rise.sw_off
		&& !rise.toggle && q.hold_cnt != HOLD_W'(HOLD_CYCLES - 1)
		|=> relay_drive && q.hold_cnt == $past(q.hold_cnt) + HOLD_W'(1))
		else $error("switch-on press disturbed running hold");

	a_fall_cause: assert property ($fell(relay_drive) |-> $past(rise.sw_off
		|| rise.toggle || q.hold_cnt == HOLD_W'(HOLD_CYCLES - 1)))
		else $error("relay released without cause");

endmodule

`default_nettype wire

// ===== dv/hrt_btn.sv
`timescale 1ns/10ps
`default_nettype none
// Push-button seen through its pull resistor
module hrt_btn #(
	parameter bit ACTIVE_LOW = 1'b0 // Variant polarity
) (
	input  wire logic press, // Button held
	output logic      pin    // Pin level
);
	assign pin = press ^ ACTIVE_LOW;
endmodule
`default_nettype wire

// ===== dv/test_hrt_timer.sv
`timescale 1ns/10ps
`default_nettype none
module test_hrt_timer;
	import hrt_pkg::*;
	localparam int HOLD = 50; // Short hold keeps the run brief
	logic       core_clk = 1'b0;
	logic       rst_n    = 1'b0;
	logic [2:0] prs      = 3'h0; // On, off, toggle
	wire  logic [2:0] pin;
	wire  logic [2:0] pin_lo; // Ground-switched variant pins
	logic       relay;
	logic       relay_lo;
	int         errors   = 0;
	int         compares = 0;
	int         n;
	for (genvar i = 0; i < 3; i++) begin : g_btn
		hrt_btn u_b (.press(prs[i]), .pin(pin[i]));
		hrt_btn #(.ACTIVE_LOW(1'b1)) u_l (.press(prs[i]), .pin(pin_lo[i]));
	end
	hrt_timer #(.HOLD_CYCLES(HOLD), .ACTIVE_LOW(1'b1)) dut_lo (.core_clk(core_clk),
		.rst_n(rst_n), .sw_on_pin(pin_lo[2]), .sw_off_pin(pin_lo[1]),
		.toggle_pushbutton(pin_lo[0]), .relay_drive(relay_lo));
	hrt_timer #(.HOLD_CYCLES(HOLD)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
		.sw_on_pin(pin[2]), .sw_off_pin(pin[1]), .toggle_pushbutton(pin[0]),
		.relay_drive(relay));
	initial forever #5 core_clk = ~core_clk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %0t seen %0h exp %0h", $time, s, e);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge core_clk);
	endtask
	// Bounded wait for a relay level, n holds cycles spent
	task automatic wt(input logic v, input int lim);
		n = 0;
		while (relay !== v && n < lim) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic push(input int b, input int k);
		prs[b] = 1'b1;
		cyc(k);
		prs[b] = 1'b0;
	endtask
	task automatic summarize;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Pulses below the debounce span must vanish
	task automatic t_glitch;
		push(2, 3);
		cyc(20);
		chk(relay, 0);
		$display("glitch done");
	endtask
	// Held on button: one period only, no restart
	task automatic t_held;
		prs[2] = 1'b1;
		wt(1, 20);
		chk(n >= 8 && n <= 12, 1);
		cyc(40);
		chk(relay, 1);
		chk(relay_lo, 1);
		wt(0, 20);
		chk(n >= 8 && n <= 12, 1);
		cyc(30);
		chk(relay, 0);
		chk(relay_lo, 0);
		prs[2] = 1'b0;
		cyc(12);
		$display("held done");
	endtask
	task automatic t_off;
		push(2, 12);
		wt(1, 20);
		cyc(10);
		push(1, 12);
		chk(relay, 0);
		cyc(12);
		$display("off done");
	endtask
	task automatic t_tgl;
		push(0, 12);
		wt(1, 20);
		chk(relay, 1);
		chk(relay_lo, 1);
		cyc(10);
		push(0, 12);
		wt(0, 20);
		chk(relay, 0);
		cyc(10);
		push(0, 12);
		wt(1, 20);
		wt(0, 60);
		chk({n > 30, relay}, 2'h2);
		$display("toggle done");
	endtask
	initial begin
		cyc(10);
		chk(relay, 0);
		rst_n = 1'b1;
		cyc(2);
		t_glitch();
		t_held();
		t_off();
		t_tgl();
		summarize();
	end
	// Tests need about 3 us
	initial begin
		#20us;
		errors++;
		summarize();
	end
endmodule
`default_nettype wire
